// File: aio_pkg.sv
package aio_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] AIO_OFS_IN1 = 4'h0;
    localparam logic [3:0] AIO_OFS_IN2 = 4'h1;
    localparam logic [3:0] AIO_OFS_IN3 = 4'h2;
    localparam logic [3:0] AIO_OFS_IN4 = 4'h3;
    localparam logic [3:0] AIO_OFS_OUT1 = 4'h4;
    localparam logic [3:0] AIO_OFS_OUT2 = 4'h5;
    localparam logic [3:0] AIO_OFS_STATUS = 4'h6;
    localparam logic [3:0] AIO_OFS_ERRCODE = 4'h7;
    localparam logic [3:0] AIO_OFS_CONFIG = 4'h8;
    localparam logic [3:0] AIO_OFS_IRQ_ST = 4'h9;
    localparam logic [3:0] AIO_OFS_IRQ_MASK = 4'hA;
    // ****************************************
    // Fields and codes
    // ****************************************
    localparam int AIO_FLAG_BIT = 15;
    localparam int AIO_CODE_LSB = 8;
    localparam int AIO_EN_LSB = 8;
    localparam logic [1:0] AIO_RNG_BIP = 2'h0;
    localparam logic [1:0] AIO_RNG_U10 = 2'h1;
    localparam logic [1:0] AIO_RNG_U5 = 2'h2;
    localparam logic [1:0] AIO_RNG_RSV = 2'h3;
    localparam logic [7:0] AIO_ERR_NONE = 8'h00;
    localparam logic [7:0] AIO_ERR_HW = 8'h01;
    localparam logic [7:0] AIO_ERR_CFG = 8'h03;
    localparam logic [7:0] AIO_ERR_CONV = 8'h04;
    localparam logic [15:0] AIO_BIP_MIN = 16'hF800;
    localparam logic [15:0] AIO_BIP_MAX = 16'h07FF;
    localparam logic [15:0] AIO_CUR_MAX = 16'h07FF;
    localparam logic [15:0] AIO_CFG_RESET = 16'h0000;
    localparam logic [15:0] AIO_WORD_RESET = 16'h0000;
    // ****************************************
    // Timing
    // ****************************************
    localparam int AIO_CLK_NS = 10;
    localparam int AIO_SCAN_NS = 1000;
    localparam int AIO_SCAN_CYCLES = (AIO_SCAN_NS + AIO_CLK_NS - 1) / AIO_CLK_NS;
    localparam int AIO_SCAN_W = 12;
    typedef enum logic [0:0] {
        AIO_ST_CFG = 1'b0,
        AIO_ST_RUN = 1'b1
    } aio_state_t;
endpackage

// File: aio_board.sv
module aio_board #(
    parameter int SCAN_CYCLES = aio_pkg::AIO_SCAN_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [15:0] rdata_o,
    input wire logic [3:0][11:0] adc_raw_i,
    input wire logic hw_fault_i,
    input wire logic conv_err_i,
    input wire logic [1:0] out_current_i,
    output logic [1:0][11:0] dac_code_o,
    output logic dac_load_o,
    output logic board_err_o,
    output logic irq_o
);
    import aio_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        aio_state_t st;
        logic [AIO_SCAN_W-1:0] tick;
        logic [3:0][11:0] raw1;
        logic [3:0][11:0] raw2;
        logic [1:0] flt1;
        logic [1:0] flt2;
        logic [1:0] orng1;
        logic [1:0] orng2;
        logic [3:0][15:0] res;
        logic [1:0][15:0] out_set;
        logic [15:0] cfg_wr;
        logic [11:0] cfg_act;
        logic [1:0] orng_act;
        logic [7:0] code;
        logic berr;
        logic [1:0][11:0] dac;
        logic dac_load;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic irq;
        logic [15:0] rdata;
    } aio_regs_t;

    aio_regs_t q;
    aio_regs_t d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] aio_conv(input logic [11:0] raw, input logic [1:0] rng, input logic dis);
        logic [15:0] r;
        r = 16'h0000;
        if (!dis) begin
            case (rng)
                AIO_RNG_BIP: r = {{5{~raw[11]}}, raw[10:0]};
                AIO_RNG_U10, AIO_RNG_U5: r = {4'h0, raw};
                default: r = 16'h0000;
            endcase
        end
        return r;
    endfunction

    function automatic logic [11:0] aio_dac(input logic [15:0] s, input logic cur);
        logic [11:0] c;
        c = 12'h000;
        if (cur) begin
            if (s[15]) begin
                c = 12'h000;
            end else if (s > AIO_CUR_MAX) begin
                c = {1'b0, AIO_CUR_MAX[10:0]};
            end else begin
                c = {1'b0, s[10:0]};
            end
        end else begin
            if ($signed(s) < $signed(AIO_BIP_MIN)) begin
                c = {~AIO_BIP_MIN[11], AIO_BIP_MIN[10:0]};
            end else if ($signed(s) > $signed(AIO_BIP_MAX)) begin
                c = {~AIO_BIP_MAX[11], AIO_BIP_MAX[10:0]};
            end else begin
                c = {~s[11], s[10:0]};
            end
        end
        return c;
    endfunction

    function automatic logic aio_oor(input logic [15:0] s, input logic cur);
        logic o;
        if (cur) begin
            o = s[15] || (s > AIO_CUR_MAX);
        end else begin
            o = ($signed(s) < $signed(AIO_BIP_MIN)) || ($signed(s) > $signed(AIO_BIP_MAX));
        end
        return o;
    endfunction

    logic scan;
    assign scan = (q.tick == AIO_SCAN_W'(SCAN_CYCLES - 1));

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [1:0] irq_set;
        logic [1:0] irq_clr;
        logic cfg_bad;
        logic oor;
        irq_set = 2'b00;
        irq_clr = 2'b00;
        cfg_bad = 1'b0;
        oor = 1'b0;
        d = q;
        d.raw1 = adc_raw_i;
        d.raw2 = q.raw1;
        d.flt1 = {conv_err_i, hw_fault_i};
        d.flt2 = q.flt1;
        d.orng1 = out_current_i;
        d.orng2 = q.orng1;
        d.dac_load = 1'b0;
        d.tick = scan ? '0 : q.tick + AIO_SCAN_W'(1);
        case (q.st)
            AIO_ST_CFG: begin
                if (scan) begin
                    d.cfg_act = q.cfg_wr[11:0];
                    d.orng_act = q.orng2;
                    d.st = AIO_ST_RUN;
                end
            end
            AIO_ST_RUN: begin
                if (scan) begin
                    for (int i = 0; i < 4; i++) begin
                        d.res[i] = aio_conv(q.raw2[i], q.cfg_act[2*i +: 2], q.cfg_act[AIO_EN_LSB + i]);
                    end
                    for (int j = 0; j < 2; j++) begin
                        d.dac[j] = aio_dac(q.out_set[j], q.orng_act[j]);
                    end
                    d.dac_load = 1'b1;
                    irq_set[0] = 1'b1;
                end
            end
            default: d.st = AIO_ST_CFG;
        endcase
        // Error code and flag
        for (int i = 0; i < 4; i++) begin
            if (q.cfg_act[2*i +: 2] == AIO_RNG_RSV) begin
                cfg_bad = 1'b1;
            end
        end
        for (int j = 0; j < 2; j++) begin
            if (aio_oor(q.out_set[j], q.orng_act[j])) begin
                oor = 1'b1;
            end
        end
        if (q.st != AIO_ST_RUN) begin
            d.code = AIO_ERR_NONE;
        end else if (q.flt2[0]) begin
            d.code = AIO_ERR_HW;
        end else if (cfg_bad) begin
            d.code = AIO_ERR_CFG;
        end else if (q.flt2[1] || oor) begin
            d.code = AIO_ERR_CONV;
        end else begin
            d.code = AIO_ERR_NONE;
        end
        d.berr = (d.code != AIO_ERR_NONE);
        if (d.berr && !q.berr) begin
            irq_set[1] = 1'b1;
        end
        // Register writes
        if (we_i) begin
            case (addr_i)
                AIO_OFS_OUT1: d.out_set[0] = wdata_i;
                AIO_OFS_OUT2: d.out_set[1] = wdata_i;
                AIO_OFS_CONFIG: d.cfg_wr = wdata_i;
                AIO_OFS_IRQ_MASK: d.irq_mask = wdata_i[1:0];
                default: d.cfg_wr = d.cfg_wr;
            endcase
        end
        // Register reads
        d.rdata = 16'h0000;
        if (re_i) begin
            case (addr_i)
                AIO_OFS_IN1: d.rdata = q.res[0];
                AIO_OFS_IN2: d.rdata = q.res[1];
                AIO_OFS_IN3: d.rdata = q.res[2];
                AIO_OFS_IN4: d.rdata = q.res[3];
                AIO_OFS_OUT1: d.rdata = q.out_set[0];
                AIO_OFS_OUT2: d.rdata = q.out_set[1];
                AIO_OFS_STATUS: d.rdata = {q.berr, 15'h0000};
                AIO_OFS_ERRCODE: d.rdata = {q.code, 8'h00};
                AIO_OFS_CONFIG: d.rdata = q.cfg_wr;
                AIO_OFS_IRQ_ST: begin
                    d.rdata = {14'h0000, q.irq_st};
                    irq_clr = 2'b11;
                end
                AIO_OFS_IRQ_MASK: d.rdata = {14'h0000, q.irq_mask};
                default: d.rdata = 16'h0000;
            endcase
        end
        // Set wins over clear
        d.irq_st = (q.irq_st & ~irq_clr) | irq_set;
        d.irq = |(q.irq_st & q.irq_mask);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= AIO_ST_CFG;
            q.cfg_wr <= AIO_CFG_RESET;
            q.out_set <= {AIO_WORD_RESET, AIO_WORD_RESET};
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign dac_code_o = q.dac;
    assign dac_load_o = q.dac_load;
    assign board_err_o = q.berr;
    assign irq_o = q.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_RESULT_UPDATE: assert property (
        (q.st == AIO_ST_RUN && scan) |=> q.res[0] == aio_conv($past(q.raw2[0]), q.cfg_act[1:0], q.cfg_act[8]))
        else $error("input one result not refreshed on scan");

    AST_BIP_RANGE: assert property (
        (q.st == AIO_ST_RUN && q.cfg_act[3:2] == AIO_RNG_BIP && !q.cfg_act[9] && dac_load_o)
        |-> (q.res[1][15:11] == 5'h00 || q.res[1][15:11] == 5'h1F))
        else $error("bipolar result outside F800 to 07FF");

    AST_UNI_RANGE: assert property (
        (q.st == AIO_ST_RUN && (q.cfg_act[5:4] == AIO_RNG_U10 || q.cfg_act[5:4] == AIO_RNG_U5) && dac_load_o)
        |-> q.res[2][15:12] == 4'h0)
        else $error("unipolar result above 0FFF");

    AST_SCAN_LOAD: assert property (
        dac_load_o |=> !dac_load_o [*8])
        else $error("output load repeated within a scan");

    AST_DAC_CURRENT: assert property (
        dac_load_o |-> ((!q.orng_act[0] || !dac_code_o[0][11]) && (!q.orng_act[1] || !dac_code_o[1][11])))
        else $error("current output code above 07FF");

    AST_FLAG_FOLLOWS_CODE: assert property (
        board_err_o == (q.code != AIO_ERR_NONE))
        else $error("board error flag disagrees with code");

    AST_CODE_VALID: assert property (
        q.code == AIO_ERR_NONE || q.code == AIO_ERR_HW || q.code == AIO_ERR_CFG || q.code == AIO_ERR_CONV)
        else $error("error code holds an undefined value");

    AST_DISABLED_ZERO: assert property (
        (q.st == AIO_ST_RUN && q.cfg_act[11] && scan) |=> q.res[3] == 16'h0000)
        else $error("disabled input produced a result");

    AST_CFG_FROZEN: assert property (
        (q.st == AIO_ST_RUN) |=> $stable(q.cfg_act) && $stable(q.orng_act))
        else $error("active configuration changed after power-on");

    AST_HW_FAULT_CODE: assert property (
        (q.st == AIO_ST_RUN && q.flt2[0]) |=> (q.code == AIO_ERR_HW && board_err_o))
        else $error("hardware fault not reported");

    // ****************************************
    // Register and interrupt checks
    // ****************************************
    AST_RDATA_IDLE: assert property (
        !re_i |=> rdata_o == 16'h0000)
        else $error("read data not cleared after idle cycle");

    AST_RESULT_READ: assert property (
        (re_i && addr_i == AIO_OFS_IN1) |=> rdata_o == $past(q.res[0]))
        else $error("input one result read back wrong");

    AST_SCAN_TICK: assert property (
        dac_load_o |-> q.tick == '0)
        else $error("results updated away from the scan boundary");

    AST_SCAN_IRQ: assert property (
        dac_load_o |-> q.irq_st[0])
        else $error("scan done event not recorded");

    AST_OUT1_WRITE: assert property (
        (we_i && addr_i == AIO_OFS_OUT1) |=> q.out_set[0] == $past(wdata_i))
        else $error("output one setting not stored");

    AST_OUT2_WRITE: assert property (
        (we_i && addr_i == AIO_OFS_OUT2) |=> q.out_set[1] == $past(wdata_i))
        else $error("output two setting not stored");

    AST_STATUS_READ: assert property (
        (re_i && addr_i == AIO_OFS_STATUS) |=> rdata_o == {$past(board_err_o), 15'h0000})
        else $error("status word read back wrong");

    AST_CONV_FAULT_FLAG: assert property (
        (q.st == AIO_ST_RUN && q.flt2[1]) |=> board_err_o)
        else $error("conversion fault did not raise the error flag");

    AST_CODE_READ: assert property (
        (re_i && addr_i == AIO_OFS_ERRCODE) |=> rdata_o == {$past(q.code), 8'h00})
        else $error("error code read back wrong");

    AST_CODE_BEFORE_RUN: assert property (
        (q.st == AIO_ST_CFG) |=> q.code == AIO_ERR_NONE)
        else $error("error code set before first scan");

    AST_CFG_FAULT_CODE: assert property (
        (q.st == AIO_ST_RUN && !q.flt2[0] && q.cfg_act[1:0] == AIO_RNG_RSV) |=> q.code == AIO_ERR_CFG)
        else $error("reserved range not reported");

    AST_CFG_WRITE: assert property (
        (we_i && addr_i == AIO_OFS_CONFIG) |=> q.cfg_wr == $past(wdata_i))
        else $error("configuration word not stored");

    AST_CFG_LATCH: assert property (
        (q.st == AIO_ST_CFG && scan) |=> (q.st == AIO_ST_RUN && q.cfg_act == $past(q.cfg_wr[11:0])))
        else $error("configuration not taken at first scan");

    AST_ERR_IRQ: assert property (
        $rose(board_err_o) |-> q.irq_st[1])
        else $error("error event not recorded");

    AST_IRQ_ON: assert property (
        ((q.irq_st & q.irq_mask) != 2'h0) |=> irq_o)
        else $error("interrupt missing for unmasked event");

    AST_IRQ_OFF: assert property (
        ((q.irq_st & q.irq_mask) == 2'h0) |=> !irq_o)
        else $error("interrupt raised with no unmasked event");

    AST_MASK_WRITE: assert property (
        (we_i && addr_i == AIO_OFS_IRQ_MASK) |=> q.irq_mask == $past(wdata_i[1:0]))
        else $error("interrupt mask not stored");

    AST_IRQ_READ_CLEARS: assert property (
        (re_i && addr_i == AIO_OFS_IRQ_ST && !scan && board_err_o) |=> q.irq_st == 2'h0)
        else $error("event bits not cleared by read");
endmodule

// File: aio_front_end_model.sv
module aio_front_end_model (
    input wire logic clk_i,
    input wire logic [3:0][11:0] level_i,
    input wire logic [1:0] fault_i,
    input wire logic [1:0][11:0] dac_code_i,
    input wire logic dac_load_i,
    output logic [3:0][11:0] adc_raw_o,
    output logic hw_fault_o,
    output logic conv_err_o,
    output logic [1:0][11:0] dac_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // *****
    // Converters track the analog levels
    // *****
    always_ff @(posedge clk_i) begin
        adc_raw_o <= level_i;
        {conv_err_o, hw_fault_o} <= fault_i;
    end
    // *****
    // Output stage takes codes at each load
    // *****
    always_ff @(posedge clk_i) begin
        if (dac_load_i) begin
            dac_seen_o <= dac_code_i;
        end
    end
endmodule

// File: aio_board_tb_top.sv
module aio_board_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aio_pkg::*;
    localparam int SCAN = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [3:0][11:0] level = {12'h555, 12'h3C5, 12'hABC, 12'hFFF};
    logic [1:0] flt = 2'h0;
    logic [1:0] cur = 2'h2;
    logic [15:0] rdata;
    logic [3:0][11:0] raw;
    logic hw, ce, dac_load, board_err, irq;
    logic [1:0][11:0] dac_code, seen;
    logic [1:0] fl [3] = '{2'h1, 2'h2, 2'h3};
    logic [7:0] ec [3] = '{8'h01, 8'h04, 8'h01};
    int miscompares = 0;
    int compares = 0;

    aio_board #(.SCAN_CYCLES(SCAN)) dut (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .we_i(we), .re_i(re), .rdata_o(rdata), .adc_raw_i(raw), .hw_fault_i(hw), .conv_err_i(ce),
        .out_current_i(cur), .dac_code_o(dac_code), .dac_load_o(dac_load), .board_err_o(board_err),
        .irq_o(irq));
    aio_front_end_model fe (.clk_i(clk), .level_i(level), .fault_i(flt), .dac_code_i(dac_code),
        .dac_load_i(dac_load), .adc_raw_o(raw), .hw_fault_o(hw), .conv_err_o(ce), .dac_seen_o(seen));

    initial begin
        forever #5 clk = ~clk;
    end
    // *****
    // Bus and check tasks
    // *****
    task automatic give_verdict();
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp_v);
        compares++;
        if (got !== exp_v) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, got, exp_v);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp_v);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        check(rdata, exp_v);
    endtask

    task automatic wait_load(input int n);
        int t;
        for (int k = 0; k < n; k++) begin
            t = 0;
            do begin
                @(posedge clk);
                #1;
                t++;
            end while (dac_load !== 1'b1 && t < 4 * SCAN);
            if (dac_load !== 1'b1) begin
                miscompares++;
                $display("wrong value at %0t: no converter load", $time);
                give_verdict();
            end
        end
        repeat (3) @(posedge clk);
    endtask
    // *****
    // Main sequence
    // *****
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(AIO_OFS_CONFIG, AIO_CFG_RESET);
        rd(AIO_OFS_ERRCODE, 16'h0000);
        wr(AIO_OFS_CONFIG, 16'h0824);
        wr(AIO_OFS_OUT1, 16'hF800);
        wr(AIO_OFS_OUT2, 16'h0123);
        wr(AIO_OFS_IRQ_MASK, 16'h0001);
        wait_load(2);
        rd(AIO_OFS_IN1, 16'h07FF);
        rd(AIO_OFS_IN2, 16'h0ABC);
        rd(AIO_OFS_IN3, 16'h03C5);
        rd(AIO_OFS_IN4, 16'h0000);
        check({4'h0, seen[0]}, 16'h0000);
        check({4'h0, seen[1]}, 16'h0123);
        check({15'h0000, irq}, 16'h0001);
        rd(AIO_OFS_IRQ_ST, 16'h0001);
        @(posedge clk);
        #1;
        check({15'h0000, irq}, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(AIO_OFS_IN1, 16'h1234);
        rd(AIO_OFS_IN1, 16'h07FF);
        wr(AIO_OFS_CONFIG, 16'h0000);
        wr(AIO_OFS_OUT1, 16'h07FF);
        wr(AIO_OFS_OUT2, 16'h0800);
        wr(AIO_OFS_IRQ_MASK, 16'h0002);
        wait_load(1);
        rd(AIO_OFS_IN4, 16'h0000);
        check({4'h0, seen[0]}, 16'h0FFF);
        check({4'h0, seen[1]}, 16'h07FF);
        rd(AIO_OFS_ERRCODE, 16'h0400);
        rd(AIO_OFS_STATUS, 16'h8000);
        check({15'h0000, board_err & irq}, 16'h0001);
        rd(AIO_OFS_IRQ_ST, 16'h0003);
        wr(AIO_OFS_OUT2, 16'h07FF);
        wait_load(1);
        rd(AIO_OFS_ERRCODE, 16'h0000);
        rd(AIO_OFS_STATUS, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            flt <= fl[i];
            repeat (6) @(posedge clk);
            #1;
            check({15'h0000, board_err}, 16'h0001);
            rd(AIO_OFS_ERRCODE, {ec[i], 8'h00});
            rd(AIO_OFS_STATUS, 16'h8000);
            @(posedge clk);
            flt <= 2'h0;
            repeat (6) @(posedge clk);
            rd(AIO_OFS_ERRCODE, 16'h0000);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(AIO_OFS_CONFIG, 16'h0003);
        wait_load(2);
        rd(AIO_OFS_ERRCODE, 16'h0300);
        rd(AIO_OFS_IN1, 16'h0000);
        rd(AIO_OFS_IN2, 16'h02BC);
        rd(AIO_OFS_IN3, 16'hFBC5);
        rd(AIO_OFS_IN4, 16'hFD55);
        rd(AIO_OFS_IRQ_MASK, 16'h0000);
        give_verdict();
    end
endmodule
